// ---- rtl/pgp_defines.vh ----
// Register offsets, field positions and reset values of the port block
`ifndef PGP_DEFINES_VH
`define PGP_DEFINES_VH

// ****************************************************************
// Register byte addresses (index times four)
// ****************************************************************
`define PGP_IDX_DATA      8'h02
`define PGP_IDX_DIR       8'hf6
`define PGP_IDX_CFG       8'hf7
`define PGP_ADDR_DATA     12'h008
`define PGP_ADDR_DIR      12'h3d8
`define PGP_ADDR_CFG      12'h3dc

// ****************************************************************
// Field positions of the port-3 configuration register
// ****************************************************************
`define PGP_CFG_PUSHPULL  0
`define PGP_CFG_ANALOG    1
`define PGP_CFG_AMP_EN    2

// ****************************************************************
// Reset values
// ****************************************************************
`define PGP_DIR_RST       8'hff
`define PGP_CFG_RST       3'h0
`define PGP_CFG_RSVD      5'h1f
`define PGP_OUT_RST       8'hff

// ****************************************************************
// AXI responses
// ****************************************************************
`define PGP_RESP_OKAY     2'h0
`define PGP_RESP_SLVERR   2'h2

`endif

// ---- rtl/pgp_sync.v ----
// Two-flop synchroniser for a bus of pin inputs
`timescale 1ns/1ps

module pgp_sync #(
    parameter WIDTH = 8
) (
    // Clock and reset
    input  wire             aclk,
    input  wire             aresetn,
    // Raw and synchronised levels
    input  wire [WIDTH-1:0] din,
    output reg  [WIDTH-1:0] dout
);

    reg [WIDTH-1:0] meta_r;  // First stage, read only by second

    // ****************************************************************
    // Synchroniser stages
    // ****************************************************************
    // Both stages clear on reset
    always @(posedge aclk) begin
        if (!aresetn) begin
            meta_r <= {WIDTH{1'b0}};
            dout   <= {WIDTH{1'b0}};
        end else begin
            meta_r <= din;
            dout   <= meta_r;
        end
    end

endmodule

// ---- rtl/pgp_port.v ----
// Port-2 bidirectional port and port-3 input configuration, AXI4-Lite
//
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/1ps
`include "pgp_defines.vh"


module pgp_port (
    // Clock and reset
    input  wire        aclk,
    input  wire        aresetn,
    // Stop-mode recovery reset pulse
    input  wire        stop_mode_recovery,
    // AXI4-Lite write address
    input  wire [11:0] s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    // AXI4-Lite write data
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    // AXI4-Lite write response
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    // AXI4-Lite read address
    input  wire [11:0] s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    // AXI4-Lite read data
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // Port-2 pins
    input  wire [7:0]  port2_pin_i,
    output reg  [7:0]  port2_pin_o,
    output reg  [7:0]  port2_pin_oe,
    // Port-3 low input pins
    input  wire [3:0]  port3_pin_i,
    // Digital port-3 inputs to the core
    output reg  [3:0]  port3_digital,
    // Analog routing controls
    output reg  [3:0]  port3_comp_sel,
    output reg         first_comparator_en,
    output reg         amp_en
);

    // ****************************************************************
    // Storage
    // ****************************************************************
    // Direction and config change only on a bus write or system
    // reset; nothing else in the block may touch them.
    reg  [7:0] port2_pin_data_r;      // Output latch, written by software
    reg  [7:0] port2_pin_direction_r; // One means input
    reg  [2:0] port3_input_config_r;  // Writable low config bits
    reg  [11:0] aw_addr_r;            // Captured write address
    reg         aw_have_r;            // Write address held
    reg  [31:0] w_data_r;             // Captured write data
    reg  [3:0]  w_strb_r;             // Captured byte enables
    reg         w_have_r;             // Write data held
    wire [7:0]  port2_sync;           // Synchronised pin levels
    wire [3:0]  port3_sync;           // Synchronised port-3 levels
    wire        wr_go;                // Both halves of a write present
    wire        rd_go;                // Read accepted this cycle

    // ****************************************************************
    // Address check shared by both channels
    // ****************************************************************
    // Codes: 0 unmapped, 1 data, 2 direction, 3 config. The write
    // commit, the write response and the read mux all use this one
    // decode, so they can never disagree about the map.
    function [1:0] pgp_decode;
        input [11:0] addr;
        begin
            if (addr == `PGP_ADDR_DATA)
                pgp_decode = 2'h1;
            else if (addr == `PGP_ADDR_DIR)
                pgp_decode = 2'h2;
            else if (addr == `PGP_ADDR_CFG)
                pgp_decode = 2'h3;
            else
                pgp_decode = 2'h0;
        end
    endfunction

    // ****************************************************************
    // Pin input synchronisers
    // ****************************************************************
    // Pins are asynchronous to aclk; two stages keep a metastable
    // level away from the read mux and routing logic, at the cost of
    // two cycles of latency on every pin read.
    pgp_sync #(
        .WIDTH (8)
    ) u_sync_p2 (
        .aclk    (aclk),
        .aresetn (aresetn),
        .din     (port2_pin_i),
        .dout    (port2_sync)
    );

    // Port-3 lines go through a second synchroniser
    pgp_sync #(
        .WIDTH (4)
    ) u_sync_p3 (
        .aclk    (aclk),
        .aresetn (aresetn),
        .din     (port3_pin_i),
        .dout    (port3_sync)
    );

    // ****************************************************************
    // Write channel handshake
    // ****************************************************************
    // Each half is taken while its holding slot is empty and no
    // response waits, so address and data may arrive in any order.
    assign s_axi_awready = !aw_have_r && !s_axi_bvalid;
    assign s_axi_wready  = !w_have_r && !s_axi_bvalid;
    assign wr_go         = aw_have_r && w_have_r && !s_axi_bvalid;

    // The response is decided from the held address, so a write to an
    // unmapped offset still completes and reports a slave error.
    // Capture write halves and issue the response
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_addr_r    <= 12'h000;
            aw_have_r    <= 1'b0;
            w_data_r     <= 32'h0000_0000;
            w_strb_r     <= 4'h0;
            w_have_r     <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `PGP_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr_r <= s_axi_awaddr;
                aw_have_r <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
                w_have_r <= 1'b1;
            end
            if (wr_go) begin
                // Both halves in hand: commit and answer
                aw_have_r    <= 1'b0;
                w_have_r     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (pgp_decode(aw_addr_r) == 2'h0)
                    s_axi_bresp <= `PGP_RESP_SLVERR;
                else
                    s_axi_bresp <= `PGP_RESP_OKAY;
            end else if (s_axi_bvalid && s_axi_bready) begin
                // Response taken: the next write may be accepted
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Register file
    // ****************************************************************
    // Stop-mode recovery deliberately touches no register here: the
    // direction and config bits must keep their values through it.
    always @(posedge aclk) begin
        if (!aresetn) begin
            port2_pin_data_r      <= `PGP_OUT_RST;
            port2_pin_direction_r <= `PGP_DIR_RST;
            port3_input_config_r  <= `PGP_CFG_RST;
        // Only byte lane 0 carries register bits
        end else if (wr_go && w_strb_r[0]) begin
            case (pgp_decode(aw_addr_r))
                2'h1: begin
                    // Latch only shows on pins set as outputs
                    port2_pin_data_r <= w_data_r[7:0];
                end
                2'h2: begin
                    // A zero bit turns its pin into an output
                    port2_pin_direction_r <= w_data_r[7:0];
                end
                2'h3: begin
                    // Upper bits are not stored at all
                    port3_input_config_r <= w_data_r[2:0];
                end
                default: begin
                    // Unmapped: nothing stored
                end
            endcase
        end
    end
    // The recovery input is sampled nowhere on purpose

    // ****************************************************************
    // Read channel
    // ****************************************************************
    // One read in flight: a new address waits until the data held in
    // the output register has been taken.
    assign s_axi_arready = !s_axi_rvalid;
    assign rd_go         = s_axi_arvalid && s_axi_arready;

    // Read data comes from a register, one cycle after the address
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `PGP_RESP_OKAY;
        end else if (rd_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `PGP_RESP_OKAY;
            case (pgp_decode(s_axi_araddr))
                2'h1: begin
                    // Live pin level, input or output alike
                    s_axi_rdata <= {24'h000000, port2_sync};
                end
                2'h2: begin
                    // Direction bits read back as written
                    s_axi_rdata <= {24'h000000, port2_pin_direction_r};
                end
                2'h3: begin
                    s_axi_rdata <= {24'h000000, `PGP_CFG_RSVD,
                                    port3_input_config_r};
                end
                default: begin
                    // Unmapped offset: zero data, slave error
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= `PGP_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ****************************************************************
    // Port-2 pin drive
    // ****************************************************************
    // Drive value mirrors the data latch; the enable decides whether
    // the pin is driven at all. Open-drain outputs are never driven
    // high, so the far side or a pull-up sets a released one.
    // Both outputs are registered, one edge behind the registers.
    always @(posedge aclk) begin
        if (!aresetn) begin
            port2_pin_o  <= 8'h00;
            port2_pin_oe <= 8'h00;
        end else begin
            // Drive value follows the latch
            port2_pin_o <= port2_pin_data_r;
            if (port3_input_config_r[`PGP_CFG_PUSHPULL]) begin
                // Push-pull: every output pin driven both ways
                port2_pin_oe <= ~port2_pin_direction_r;
            end else begin
                // Open-drain: drive only the zeros
                port2_pin_oe <= ~port2_pin_direction_r &
                                ~port2_pin_data_r;
            end
        end
    end

    // ****************************************************************
    // Port-3 input routing
    // ****************************************************************
    // Registered so the routing outputs come from flip-flops
    // Controls follow a config write one edge later
    always @(posedge aclk) begin
        if (!aresetn) begin
            port3_digital       <= 4'h0;
            port3_comp_sel      <= 4'h0;
            first_comparator_en <= 1'b0;
            amp_en              <= 1'b0;
        end else begin
            // Amplifier follows bit 2 alone
            amp_en <= port3_input_config_r[`PGP_CFG_AMP_EN];
            if (!port3_input_config_r[`PGP_CFG_ANALOG]) begin
                // Digital mode passes levels through
                port3_digital       <= port3_sync;
                // No line is handed to a comparator
                port3_comp_sel      <= 4'h0;
                first_comparator_en <= 1'b0;
            end else begin
                // Digital view forced low while lines are analog
                port3_digital <= 4'h0;
                // Line one goes to comparator only without amp
                port3_comp_sel <= {2'h3,
                    ~port3_input_config_r[`PGP_CFG_AMP_EN], 1'b1};
                // Amplifier takes the first comparator's place
                first_comparator_en <=
                    ~port3_input_config_r[`PGP_CFG_AMP_EN];
            end
        end
    end

endmodule

// ---- testbench/pgp_pin_model.sv ----
// External port-2 pin model: driven level or far-side level when released
`timescale 1ns/1ps

module pgp_pin_model (
    // Drive from the port
    input  wire [7:0] pin_o,
    input  wire [7:0] pin_oe,
    // Far-side level of each released pin
    input  wire [7:0] ext,
    // Resolved wire level
    output wire [7:0] level
);
    // Released pins follow the far side, never the last driven value
    assign level = (pin_oe & pin_o) | (~pin_oe & ext);
endmodule

// ---- testbench/pgp_port_properties.sv ----
// Port-level assertions for the port block
`timescale 1ns/1ps

module pgp_port_properties (
    // Clock and reset
    input wire        aclk,
    input wire        aresetn,
    // Bus handshakes
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire [1:0]  s_axi_bresp,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    // Port-3 routing
    input wire [3:0]  port3_pin_i,
    input wire [3:0]  port3_digital,
    input wire [3:0]  port3_comp_sel,
    input wire        first_comparator_en,
    input wire        amp_en
);
    // ****************************************************************
    // One clock domain, reset kills every check
    // ****************************************************************
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_read_latency: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid) else $error("read answer late");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata moved");
    a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while busy");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp moved");
    a_wr_blocked: assert property (s_axi_bvalid
        |-> !s_axi_awready && !s_axi_wready) else $error("write overlap");
    a_wr_answer: assert property (s_axi_awvalid && s_axi_awready &&
        s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
        else $error("write answer late");
    a_amp_replace: assert property (amp_en
        |-> !first_comparator_en && !port3_comp_sel[1])
        else $error("amplifier and comparator both on line one");
    a_analog_route: assert property (port3_comp_sel[0]
        |-> port3_digital == 4'h0 && port3_comp_sel[3:2] == 2'h3)
        else $error("analog routing wrong");
    a_first_comp: assert property (first_comparator_en
        |-> port3_comp_sel[1]) else $error("line one not routed");
    a_digital_follow: assert property ($past(aresetn, 3) &&
        $past(aresetn, 2) && $past(aresetn) && !port3_comp_sel[0] &&
        !$past(port3_comp_sel[0], 3)
        |-> port3_digital == $past(port3_pin_i, 3))
        else $error("digital input not following pin");
endmodule

bind pgp_port pgp_port_properties u_pgp_port_properties (.*);

// ---- testbench/testbench.sv ----
// Self-checking bench of the port block
`timescale 1ns/1ps
`include "pgp_defines.vh"

module testbench;
    // ****************************************************************
    // Stimulus and observed signals
    // ****************************************************************
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic        stop_mode_recovery = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h0;
    logic        s_axi_awvalid = 1'b0;
    wire         s_axi_awready;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'h0;
    logic        s_axi_wvalid = 1'b0;
    wire         s_axi_wready;
    wire  [1:0]  s_axi_bresp;
    wire         s_axi_bvalid;
    logic        s_axi_bready = 1'b0;
    logic [11:0] s_axi_araddr = 12'h0;
    logic        s_axi_arvalid = 1'b0;
    wire         s_axi_arready;
    wire  [31:0] s_axi_rdata;
    wire  [1:0]  s_axi_rresp;
    wire         s_axi_rvalid;
    logic        s_axi_rready = 1'b0;
    wire  [7:0]  port2_pin_i, port2_pin_o, port2_pin_oe;
    logic [3:0]  port3_pin_i = 4'h0;
    wire  [3:0]  port3_digital, port3_comp_sel;
    wire         first_comparator_en, amp_en;
    logic [7:0]  ext = 8'h0;    // Far-side pin levels
    integer      errors = 0;
    integer      checks_done = 0;
    integer      seed = 78;
    integer      i;
    integer      lag = 0;     // Edges before bready or rready rise
    reg   [31:0] rnd;         // One random draw per set-up
    reg   [7:0]  dr, dt;
    reg   [1:0]  m;
    reg          pp;

    always #4 aclk = ~aclk;

    pgp_port u_pgp_port (.aclk, .aresetn, .stop_mode_recovery,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .port2_pin_i, .port2_pin_o, .port2_pin_oe,
        .port3_pin_i, .port3_digital, .port3_comp_sel,
        .first_comparator_en, .amp_en);
    pgp_pin_model u_pgp_pin_model (.pin_o(port2_pin_o),
        .pin_oe(port2_pin_oe), .ext(ext), .level(port2_pin_i));

    // Expected enables: open-drain releases pins that hold a one
    function [7:0] eoe(input [7:0] d, input [7:0] v, input p);
        eoe = p ? ~d : ~d & ~v;
    endfunction

    task chk(input [31:0] got, input [31:0] exp);
        begin
            checks_done = checks_done + 1;
            if (got !== exp) begin
                errors = errors + 1;
                $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask

    task wrap_up;
        begin
            $display("checks=%0d errors=%0d", checks_done, errors);
            if (errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
            else $display("CHECKS NOT OK");
            $finish;
        end
    endtask

    // Bounded wait; a hang counts as a mismatch
    task guard(inout integer n);
        begin
            n = n + 1;
            if (n > 64) begin
                errors = errors + 1;
                wrap_up;
            end
        end
    endtask

    // Handshakes sampled at the falling edge, acted on at the rising one
    task wr(input [11:0] a, input [7:0] d, input [3:0] s, input [1:0] er);
        integer n;
        reg     ta, tw, tb;
        begin
            s_axi_awaddr <= a;
            s_axi_wdata <= {24'h0, d};
            s_axi_wstrb <= s;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            s_axi_bready <= (lag == 0);
            n = 0;
            tb = 1'b0;
            while (!tb) begin
                @(negedge aclk);
                ta = s_axi_awvalid & s_axi_awready;
                tw = s_axi_wvalid & s_axi_wready;
                tb = s_axi_bvalid & s_axi_bready;
                if (tb) chk({30'h0, s_axi_bresp}, {30'h0, er});
                guard(n);
                @(posedge aclk);
                if (ta) s_axi_awvalid <= 1'b0;
                if (tw) s_axi_wvalid <= 1'b0;
                if (tb) s_axi_bready <= 1'b0;
                else if (n == lag) s_axi_bready <= 1'b1;
            end
            // One idle edge, so the next call never re-drives this step
            @(posedge aclk);
        end
    endtask

    task rd(input [11:0] a, input [31:0] ed, input [1:0] er);
        integer n;
        reg     ta, tr;
        begin
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
            s_axi_rready <= (lag == 0);
            n = 0;
            tr = 1'b0;
            while (!tr) begin
                @(negedge aclk);
                ta = s_axi_arvalid & s_axi_arready;
                tr = s_axi_rvalid & s_axi_rready;
                if (tr) chk(s_axi_rdata, ed);
                if (tr) chk({30'h0, s_axi_rresp}, {30'h0, er});
                guard(n);
                @(posedge aclk);
                if (ta) s_axi_arvalid <= 1'b0;
                if (tr) s_axi_rready <= 1'b0;
                else if (n == lag) s_axi_rready <= 1'b1;
            end
            // One idle edge, so the next call never re-drives this step
            @(posedge aclk);
        end
    endtask

    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(`PGP_ADDR_DIR, 32'hff, `PGP_RESP_OKAY);
        rd(`PGP_ADDR_CFG, 32'hf8, `PGP_RESP_OKAY);
        chk({24'h0, port2_pin_oe}, 32'h0);
        // Random pin set-ups; first two drive all low, then float all
        for (i = 0; i < 12; i = i + 1) begin
            rnd = $random(seed);
            dr = (i < 2) ? 8'h00 : rnd[7:0];
            dt = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : rnd[15:8];
            pp = (i == 0) ? 1'b1 : (i == 1) ? 1'b0 : rnd[16];
            ext <= rnd[31:24];
            wr(`PGP_ADDR_CFG, {7'h0, pp}, 4'hf, `PGP_RESP_OKAY);
            wr(`PGP_ADDR_DIR, dr, 4'h1, `PGP_RESP_OKAY);
            wr(`PGP_ADDR_DATA, dt, 4'h1, `PGP_RESP_OKAY);
            repeat (4) @(posedge aclk);
            chk({24'h0, port2_pin_oe}, {24'h0, eoe(dr, dt, pp)});
            chk({24'h0, port2_pin_o & port2_pin_oe},
                {24'h0, dt & eoe(dr, dt, pp)});
            rd(`PGP_ADDR_DATA, {24'h0, (eoe(dr, dt, pp) & dt) |
                (~eoe(dr, dt, pp) & ext)}, `PGP_RESP_OKAY);
        end
        // Every amplifier and analog mode combination
        for (i = 0; i < 4; i = i + 1) begin
            m = i[1:0];
            rnd = $random(seed);
            port3_pin_i <= rnd[3:0];
            wr(`PGP_ADDR_CFG, {5'h0, m, 1'b1}, 4'h1, `PGP_RESP_OKAY);
            repeat (5) @(posedge aclk);
            chk({31'h0, amp_en}, {31'h0, m[1]});
            chk({31'h0, first_comparator_en}, {31'h0, m[0] & ~m[1]});
            chk({28'h0, port3_comp_sel},
                {28'h0, m[0] ? {2'h3, ~m[1], 1'b1} : 4'h0});
            chk({28'h0, port3_digital},
                {28'h0, m[0] ? 4'h0 : port3_pin_i});
            rd(`PGP_ADDR_CFG, {24'h0, 5'h1f, m, 1'b1}, `PGP_RESP_OKAY);
        end
        // Recovery pulse leaves both configuration registers alone
        stop_mode_recovery <= 1'b1;
        @(posedge aclk);
        stop_mode_recovery <= 1'b0;
        @(posedge aclk);
        rd(`PGP_ADDR_DIR, {24'h0, dr}, `PGP_RESP_OKAY);
        rd(`PGP_ADDR_CFG, 32'hff, `PGP_RESP_OKAY);
        // Masked write and unmapped address store nothing
        lag = 3;  // Late ready: responses must stand until taken
        wr(`PGP_ADDR_DIR, ~dr, 4'h0, `PGP_RESP_OKAY);
        rd(`PGP_ADDR_DIR, {24'h0, dr}, `PGP_RESP_OKAY);
        wr(12'h100, 8'h55, 4'h1, `PGP_RESP_SLVERR);
        rd(12'h100, 32'h0, `PGP_RESP_SLVERR);
        wrap_up;
    end
endmodule
